// [include/fsa_params.svh]
// constants for the flash self-access register block
`ifndef FSA_PARAMS_SVH
`define FSA_PARAMS_SVH

// ****************************************
// widths
// ****************************************
`define FSA_IDX_W 3
`define FSA_DATA_W 14
`define FSA_LOC_W 15
`define FSA_HI_DATA_W 6
`define FSA_HI_LOC_W 7

// ****************************************
// register word indexes (byte address = index * 4)
// ****************************************
`define FSA_IDX_VAL_LO 3'h0
`define FSA_IDX_VAL_HI 3'h1
`define FSA_IDX_LOC_LO 3'h2
`define FSA_IDX_LOC_HI 3'h3
`define FSA_IDX_CTRL 3'h4
`define FSA_ADDR_HI_ZERO 27'h000_0000

// ****************************************
// control register bit positions
// ****************************************
`define FSA_CTL_FIXED 7
`define FSA_CTL_CFG 6
`define FSA_CTL_LATCH_ONLY 5
`define FSA_CTL_ERASE 4
`define FSA_CTL_FAULT 3
`define FSA_CTL_ALLOW 2
`define FSA_CTL_WR 1
`define FSA_CTL_RD 0

// ****************************************
// fixed read values and reset values
// ****************************************
`define FSA_UNIMPL_ONE 1'h1
`define FSA_UNIMPL_ZERO 2'h0
`define FSA_RST_BYTE 8'h00
`define FSA_RST_HI_DATA 6'h00
`define FSA_RST_HI_LOC 7'h00
`define FSA_RST_WORD 32'h0000_0000
`define FSA_RST_LOC 15'h0000
`define FSA_RST_DATA 14'h0000
`define FSA_PAD_WORD 24'h00_0000

// ****************************************
// configuration space windows (location bits 14:0)
// ****************************************
`define FSA_UID_FIRST 15'h0000
`define FSA_UID_LAST 15'h0003
`define FSA_DID_FIRST 15'h0005
`define FSA_CFGW_LAST 15'h0008

`endif

// [include/fsa_pkg.sv]
// types for the flash self-access register block
`include "fsa_params.svh"
package fsa_pkg;

	typedef enum logic [1:0] {
		FSA_IDLE = 2'b00,
		FSA_READ = 2'b01,
		FSA_WAIT = 2'b10
	} fsa_state_t;

	typedef struct packed {
		logic valid;
		logic write;
		logic mapped;
		logic [`FSA_IDX_W-1:0] idx;
	} fsa_front_t;

	typedef struct packed {
		fsa_state_t state;
		logic [7:0] val_lo;
		logic [`FSA_HI_DATA_W-1:0] val_hi;
		logic [7:0] loc_lo;
		logic [`FSA_HI_LOC_W-1:0] loc_hi;
		logic cfg;
		logic latch_only;
		logic erase;
		logic fault;
		logic allow;
		logic wr;
		logic rd;
		logic [31:0] hrdata;
		logic hreadyout;
		logic hresp;
		logic [`FSA_LOC_W-1:0] flash_addr;
		logic flash_cfg;
		logic [`FSA_DATA_W-1:0] flash_wdata;
		logic flash_read;
		logic flash_latch;
		logic flash_commit;
		logic flash_erase;
	} fsa_regs_t;

endpackage

// [rtl/fsa_ahb_front.sv]
// ahb-lite address phase capture for the flash self-access registers
`include "fsa_params.svh"
module fsa_ahb_front
	import fsa_pkg::*;
(
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic hready,
	output logic take,
	output logic take_mapped,
	output logic [`FSA_IDX_W-1:0] take_idx,
	output logic dp_write,
	output logic [`FSA_IDX_W-1:0] dp_idx
);
	fsa_front_t q;
	fsa_front_t d;

	always_comb begin
		take = hsel & htrans[1] & hready;
		take_idx = haddr[`FSA_IDX_W+1:2];
		take_mapped = (haddr[31:5] == `FSA_ADDR_HI_ZERO) && (take_idx <= `FSA_IDX_CTRL)
			&& (haddr[1:0] == 2'h0);
		d = q;
		if (hready) begin
			d.valid = take;
			d.write = take & hwrite;
			d.mapped = take_mapped;
			d.idx = take_idx;
		end
		dp_write = q.valid & q.write & q.mapped;
		dp_idx = q.idx;
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			q <= '0;
		end else begin
			q <= d;
		end
	end
endmodule

// [rtl/fsa_cfg_window.sv]
// decides which locations may be read or written in configuration space
`include "fsa_params.svh"
module fsa_cfg_window
	import fsa_pkg::*;
(
	input wire logic cfg_space,
	input wire logic [`FSA_LOC_W-1:0] loc,
	output logic read_ok,
	output logic write_ok
);
	logic in_uid;
	logic in_ids;

	always_comb begin
		in_uid = (loc >= `FSA_UID_FIRST) && (loc <= `FSA_UID_LAST);
		in_ids = (loc >= `FSA_DID_FIRST) && (loc <= `FSA_CFGW_LAST);
		read_ok = !cfg_space || in_uid || in_ids;
		write_ok = !cfg_space || in_uid;
	end
endmodule

// [rtl/fsa_regs.sv]
// flash self-access register block with ahb-lite slave and flash array port
`include "fsa_params.svh"

module fsa_regs
	import fsa_pkg::*;
(
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic soft_reset,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic hready,
	input wire logic [31:0] hwdata,
	output logic [31:0] hrdata,
	output logic hreadyout,
	output logic hresp,
	output logic [`FSA_LOC_W-1:0] flash_addr,
	output logic flash_cfg,
	output logic [`FSA_DATA_W-1:0] flash_wdata,
	output logic flash_read,
	output logic flash_latch,
	output logic flash_commit,
	output logic flash_erase,
	input wire logic [`FSA_DATA_W-1:0] flash_rdata,
	input wire logic flash_done
);
	fsa_regs_t q;
	fsa_regs_t d;
	logic take;
	logic take_mapped;
	logic [`FSA_IDX_W-1:0] take_idx;
	logic dp_write;
	logic [`FSA_IDX_W-1:0] dp_idx;
	logic read_ok;
	logic write_ok;
	logic [`FSA_LOC_W-1:0] loc_q;
	logic sw_set_rd;
	logic sw_set_wr;

	// ****************************************
	// bus front and address checks
	// ****************************************
	fsa_ahb_front u_front (
		.hclk(hclk),
		.hresetn(hresetn),
		.hsel(hsel),
		.haddr(haddr),
		.htrans(htrans),
		.hwrite(hwrite),
		.hready(hready),
		.take(take),
		.take_mapped(take_mapped),
		.take_idx(take_idx),
		.dp_write(dp_write),
		.dp_idx(dp_idx)
	);

	assign loc_q = {q.loc_hi, q.loc_lo};

	fsa_cfg_window u_window (
		.cfg_space(q.cfg),
		.loc(loc_q),
		.read_ok(read_ok),
		.write_ok(write_ok)
	);

	// ****************************************
	// next state
	// ****************************************
	always_comb begin
		d = q;
		sw_set_rd = 1'b0;
		sw_set_wr = 1'b0;
		d.flash_read = 1'b0;
		d.flash_latch = 1'b0;
		d.flash_commit = 1'b0;
		d.flash_erase = 1'b0;
		d.hreadyout = 1'b1;
		d.hresp = 1'b0;

		// software writes in the data phase
		if (dp_write) begin
			case (dp_idx)
				`FSA_IDX_VAL_LO: begin
					d.val_lo = hwdata[7:0];
				end
				`FSA_IDX_VAL_HI: begin
					d.val_hi = hwdata[`FSA_HI_DATA_W-1:0];
				end
				`FSA_IDX_LOC_LO: begin
					d.loc_lo = hwdata[7:0];
				end
				`FSA_IDX_LOC_HI: begin
					d.loc_hi = hwdata[`FSA_HI_LOC_W-1:0];
				end
				`FSA_IDX_CTRL: begin
					d.cfg = hwdata[`FSA_CTL_CFG];
					d.latch_only = hwdata[`FSA_CTL_LATCH_ONLY];
					d.allow = hwdata[`FSA_CTL_ALLOW];
					d.fault = hwdata[`FSA_CTL_FAULT];
					// erase select is held while a write is running
					if (q.state != FSA_WAIT) begin
						d.erase = hwdata[`FSA_CTL_ERASE];
					end
					// launch bits can only be set by software
					sw_set_wr = hwdata[`FSA_CTL_WR];
					sw_set_rd = hwdata[`FSA_CTL_RD];
				end
				default: begin
				end
			endcase
		end

		// ****************************************
		// sequencer
		// ****************************************
		case (q.state)
			FSA_IDLE: begin
				if (q.rd) begin
					if (read_ok) begin
						d.flash_read = 1'b1;
						d.state = FSA_READ;
					end else begin
						d.val_lo = `FSA_RST_BYTE;
						d.val_hi = `FSA_RST_HI_DATA;
						d.rd = 1'b0;
					end
				end else if (q.wr) begin
					if (!q.allow || !write_ok) begin
						d.wr = 1'b0;
					end else if (q.erase) begin
						// latch-only has no say over an erase
						d.flash_erase = 1'b1;
						d.fault = 1'b1;
						d.state = FSA_WAIT;
					end else if (q.latch_only) begin
						d.flash_latch = 1'b1;
						d.wr = 1'b0;
					end else begin
						d.flash_latch = 1'b1;
						d.flash_commit = 1'b1;
						d.fault = 1'b1;
						d.state = FSA_WAIT;
					end
				end
			end
			FSA_READ: begin
				// the array answers while flash_read is high
				d.val_lo = flash_rdata[7:0];
				d.val_hi = flash_rdata[`FSA_DATA_W-1:8];
				d.rd = 1'b0;
				d.state = FSA_IDLE;
			end
			FSA_WAIT: begin
				if (flash_done) begin
					d.wr = 1'b0;
					d.erase = 1'b0;
					d.fault = 1'b0;
					d.state = FSA_IDLE;
				end
			end
			default: begin
				d.state = FSA_IDLE;
			end
		endcase

		// a set from software wins over the hardware clear
		if (sw_set_rd) begin
			d.rd = 1'b1;
		end
		if (sw_set_wr) begin
			d.wr = 1'b1;
		end

		// ****************************************
		// other resets: data bytes and fault kept
		// ****************************************
		if (soft_reset) begin
			d.loc_lo = `FSA_RST_BYTE;
			d.loc_hi = `FSA_RST_HI_LOC;
			d.cfg = 1'b0;
			d.latch_only = 1'b0;
			d.erase = 1'b0;
			d.allow = 1'b0;
			d.wr = 1'b0;
			d.rd = 1'b0;
			d.state = FSA_IDLE;
			d.flash_read = 1'b0;
			d.flash_latch = 1'b0;
			d.flash_commit = 1'b0;
			d.flash_erase = 1'b0;
		end

		// array port follows the updated registers
		d.flash_addr = {d.loc_hi, d.loc_lo};
		d.flash_cfg = d.cfg;
		d.flash_wdata = {d.val_hi, d.val_lo};

		// ****************************************
		// read data, forwarded from the same-cycle update
		// ****************************************
		if (take) begin
			d.hrdata = `FSA_RST_WORD;
			if (take_mapped && !hwrite) begin
				case (take_idx)
					`FSA_IDX_VAL_LO: begin
						d.hrdata = {`FSA_PAD_WORD, d.val_lo};
					end
					`FSA_IDX_VAL_HI: begin
						d.hrdata = {`FSA_PAD_WORD, `FSA_UNIMPL_ZERO, d.val_hi};
					end
					`FSA_IDX_LOC_LO: begin
						d.hrdata = {`FSA_PAD_WORD, d.loc_lo};
					end
					`FSA_IDX_LOC_HI: begin
						d.hrdata = {`FSA_PAD_WORD, `FSA_UNIMPL_ONE, d.loc_hi};
					end
					`FSA_IDX_CTRL: begin
						d.hrdata = {`FSA_PAD_WORD, `FSA_UNIMPL_ONE, d.cfg, d.latch_only,
							d.erase, d.fault, d.allow, d.wr, d.rd};
					end
					default: begin
						d.hrdata = `FSA_RST_WORD;
					end
				endcase
			end
		end
	end

	// ****************************************
	// state register
	// ****************************************
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			q <= '0;
			q.hreadyout <= 1'b1;
		end else begin
			q <= d;
		end
	end

	// ****************************************
	// outputs
	// ****************************************
	assign hrdata = q.hrdata;
	assign hreadyout = q.hreadyout;
	assign hresp = q.hresp;
	assign flash_addr = q.flash_addr;
	assign flash_cfg = q.flash_cfg;
	assign flash_wdata = q.flash_wdata;
	assign flash_read = q.flash_read;
	assign flash_latch = q.flash_latch;
	assign flash_commit = q.flash_commit;
	assign flash_erase = q.flash_erase;
endmodule

// [testbench/fsa_regs_sva.sv]
// port checker for the flash self-access register block
`include "fsa_params.svh"
module fsa_regs_sva
	import fsa_pkg::*;
(
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic soft_reset,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic hready,
	input wire logic [31:0] hrdata,
	input wire logic hreadyout,
	input wire logic hresp,
	input wire logic [`FSA_LOC_W-1:0] flash_addr,
	input wire logic flash_cfg,
	input wire logic flash_read,
	input wire logic flash_latch,
	input wire logic flash_commit,
	input wire logic flash_erase
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking @(posedge hclk); endclocking
	default disable iff (!hresetn);

	// ****************
	// bus read address phase at one register index
	// ****************
	sequence s_rd(logic [2:0] i);
		hsel && htrans[1] && hready && !hwrite && haddr == {`FSA_ADDR_HI_ZERO, i, 2'b00};
	endsequence

	chk_ready_high: assert property (hreadyout)
		else $error("hreadyout low");
	chk_resp_okay: assert property (!hresp)
		else $error("hresp not okay");
	chk_commit_pair: assert property (
		flash_commit |-> flash_latch && !flash_erase) else $error("commit without latch");
	chk_erase_alone: assert property (
		flash_erase |-> !flash_latch && !flash_commit) else $error("erase with latch");
	chk_read_pulse: assert property (flash_read |=> !flash_read)
		else $error("read pulse too long");
	chk_cfg_window: assert property (
		flash_read && flash_cfg |-> flash_addr <= `FSA_UID_LAST
		|| (flash_addr >= `FSA_DID_FIRST && flash_addr <= `FSA_CFGW_LAST))
		else $error("config read outside window");
	chk_hi_data_zero: assert property (s_rd(3'h1) |=> hrdata[31:6] == 26'h0)
		else $error("high data top bits not zero");
	chk_loc_top_one: assert property (s_rd(3'h3) |=> hrdata[31:7] == 25'h1)
		else $error("high location top bit not one");
	chk_ctrl_top_one: assert property (s_rd(3'h4) |=> hrdata[7])
		else $error("control top bit not one");
	chk_unmapped_zero: assert property (s_rd(3'h7) |=> hrdata == 32'h0)
		else $error("unmapped read not zero");
	chk_soft_clear: assert property (
		soft_reset |-> ##[1:2] flash_addr == 15'h0) else $error("location not cleared");
endmodule

// [testbench/testbench.sv]
// self-checking bench for the flash self-access registers
`include "fsa_params.svh"
module testbench
	import fsa_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	logic hclk, hresetn, soft_reset, hsel, hwrite, hreadyout, hresp;
	logic [31:0] haddr, hwdata, hrdata;
	logic [1:0] htrans;
	logic [2:0] hsize;
	logic [`FSA_LOC_W-1:0] flash_addr;
	logic [`FSA_DATA_W-1:0] flash_wdata, flash_rdata;
	logic flash_cfg, flash_read, flash_latch, flash_commit, flash_erase, flash_done;
	int num_errors, samples_checked, cycles;

	fsa_regs fsa_regs_inst (.hclk, .hresetn, .soft_reset, .hsel, .haddr, .htrans,
		.hwrite, .hsize, .hready(hreadyout), .hwdata, .hrdata, .hreadyout, .hresp,
		.flash_addr, .flash_cfg, .flash_wdata, .flash_read, .flash_latch,
		.flash_commit, .flash_erase, .flash_rdata, .flash_done);

	task automatic chk(string what, logic [31:0] e, logic [31:0] g);
		samples_checked++;
		if (g !== e) begin
			num_errors++;
			$display("mismatch %s expected %h seen %h", what, e, g);
		end
	endtask

	// ****************
	// bus master
	// ****************
	task automatic bus(logic w, logic [2:0] i, logic [7:0] d, output logic [31:0] q);
		@(posedge hclk);
		hsel <= 1'b1;
		htrans <= 2'b10;
		hwrite <= w;
		haddr <= {`FSA_ADDR_HI_ZERO, i, 2'b00};
		do @(posedge hclk); while (hreadyout !== 1'b1);
		htrans <= 2'b00;
		hsel <= 1'b0;
		hwdata <= {24'h0, d};
		do @(posedge hclk); while (hreadyout !== 1'b1);
		q = hrdata;
		chk("hresp", 32'h0000_0000, {31'h0000_0000, hresp});
	endtask

	task automatic wr(logic [2:0] i, logic [7:0] d);
		logic [31:0] q;
		bus(1'b1, i, d, q);
	endtask

	task automatic rd(logic [2:0] i, logic [7:0] e);
		logic [31:0] q;
		bus(1'b0, i, 8'h0, q);
		chk("register", {24'h0, e}, q);
	endtask

	// writes control, gathers {read, latch, commit, erase} pulses
	task automatic op(logic [7:0] ctl, logic [3:0] e);
		logic [3:0] seen;
		seen = 4'h0;
		wr(3'h4, ctl);
		repeat (4) begin
			@(posedge hclk);
			#1;
			seen = seen | {flash_read, flash_latch, flash_commit, flash_erase};
		end
		chk("pulses", {28'h0, e}, {28'h0, seen});
		if (e[1] | e[0]) begin
			@(posedge hclk);
			flash_done <= 1'b1;
			@(posedge hclk);
			flash_done <= 1'b0;
		end
	endtask

	task automatic t_regs;
		rd(3'h2, 8'h00);
		rd(3'h3, 8'h80);
		rd(3'h4, 8'h80);
		wr(3'h0, 8'hff);
		wr(3'h1, 8'hff);
		wr(3'h2, 8'hff);
		wr(3'h3, 8'hff);
		wr(3'h7, 8'hff);
		rd(3'h0, 8'hff);
		rd(3'h1, 8'h3f);
		rd(3'h2, 8'hff);
		rd(3'h3, 8'hff);
		rd(3'h7, 8'h00);
		wr(3'h1, 8'h15);
		rd(3'h1, 8'h15);
		wr(3'h3, 8'h2a);
		rd(3'h3, 8'haa);
	endtask

	task automatic t_soft;
		wr(3'h0, 8'h5a);
		@(posedge hclk);
		soft_reset <= 1'b1;
		@(posedge hclk);
		soft_reset <= 1'b0;
		rd(3'h2, 8'h00);
		rd(3'h3, 8'h80);
		rd(3'h0, 8'h5a);
		rd(3'h1, 8'h15);
	endtask

	task automatic t_flash;
		wr(3'h2, 8'h23);
		wr(3'h3, 8'h01);
		op(8'h01, 4'b1000);
		chk("location", 32'h123, {17'h0, flash_addr});
		rd(3'h0, 8'h5c);
		rd(3'h1, 8'h2a);
		wr(3'h3, 8'h00);
		wr(3'h2, 8'h03);
		op(8'h41, 4'b1000);
		chk("config", 32'h1, {31'h0, flash_cfg});
		wr(3'h2, 8'h04);
		op(8'h41, 4'b0000);
		rd(3'h0, 8'h00);
		rd(3'h1, 8'h00);
		op(8'h46, 4'b0000);
		wr(3'h0, 8'h5a);
		wr(3'h1, 8'h15);
		op(8'h26, 4'b0100);
		chk("wdata", 32'h155a, {18'h0, flash_wdata});
		op(8'h06, 4'b0110);
		rd(3'h4, 8'h84);
		op(8'h36, 4'b0001);
		rd(3'h4, 8'ha4);
	endtask

	task automatic end_of_test;
		$display("checks %0d errors %0d", samples_checked, num_errors);
		if (num_errors == 0 && samples_checked > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask

	initial begin
		hclk = 1'b0;
		forever #2.5 hclk = ~hclk;
	end

	always @(posedge hclk) begin
		cycles++;
		if (cycles == 3000) begin
			num_errors++;
			end_of_test();
		end
	end

	initial begin
		{hresetn, soft_reset, hsel, hwrite, flash_done} = 5'h0;
		haddr = 32'h0;
		hwdata = 32'h0;
		htrans = 2'b00;
		hsize = 3'b010;
		flash_rdata = 14'h2a5c;
		repeat (8) @(posedge hclk);
		hresetn <= 1'b1;
		t_regs();
		t_soft();
		t_flash();
		end_of_test();
	end
endmodule

bind fsa_regs fsa_regs_sva fsa_regs_sva_inst (.hclk, .hresetn, .soft_reset, .hsel,
	.haddr, .htrans, .hwrite, .hready, .hrdata, .hreadyout, .hresp, .flash_addr,
	.flash_cfg, .flash_read, .flash_latch, .flash_commit, .flash_erase);
